/* File: fpg_flash_page_lock_guard.sv */
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: unlocked ordinary pages open to every requester
// R2: locked pages: debug refused, unlocked firmware resets
// R3: lock page access: open unless any page locked
// R4: lock byte reads follow the lock page rule
// R5: lock page erase unlocked: debug only, firmware resets
// R6: lock page erase when locked: only device erase
// R7: locking more pages: debug refused, firmware resets
// R8: unlocking pages: debug refused, firmware resets
// R9: reserved area: debug refused, firmware resets
// R10: flash error reset sets error flag after reset
// R11: forbidden debug requests dropped, never reset
// R12: any lock also locks the lock page
// R13: written lock byte changes only by device erase; a lock page erase also clears it while no lock is active yet
// R14: firmware lock write takes effect after reset
// R15: firmware modify needs monitor enabled and selected
// R16: device erase clears all pages and lock byte
// R17: firmware enables monitor before selecting it; the guard accepts a select write whether or not the monitor is enabled
// R18: power-on enables monitor, other resets keep it
// R19: cleared lock bit locks four pages; refused untouched
module fpg_flash_page_lock_guard
  import fpg_pkg::*;
(
  // clock and power-on reset
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 RESET_I,
  // device reset from any source, and nonvolatile lock byte
  input  wire logic                 DEV_RESET_I,
  input  wire logic [LOCK_BITS-1:0] LOCK_BYTE_NV_I,
  // flash request
  input  wire logic                 REQ_VALID_I,
  input  wire logic                 REQ_SRC_I,
  input  wire logic [1:0]           REQ_OP_I,
  input  wire logic [ADDR_W-1:0]    REQ_ADDR_I,
  input  wire logic [7:0]           REQ_WDATA_I,
  input  wire logic [PAGE_W-1:0]    FW_EXEC_PAGE_I,
  // supply monitor control written by firmware
  input  wire logic                 SMON_EN_WE_I,
  input  wire logic                 SMON_EN_I,
  input  wire logic                 PF_SEL_WE_I,
  input  wire logic                 PF_SEL_I,
  // granted operation towards the flash array
  output logic                      GRANT_O,
  output logic [1:0]                GRANT_OP_O,
  output logic [ADDR_W-1:0]         GRANT_ADDR_O,
  output logic [7:0]                GRANT_WDATA_O,
  // refusals and resets
  output logic                      REFUSE_O,
  output logic                      FLASH_ERROR_RESET_O,
  output logic                      FLASH_ERROR_FLAG_O,
  // status
  output logic                      SUPPLY_MONITOR_ENABLE_O,
  output logic                      POWER_FAIL_RESET_FLAG_O,
  output logic [LOCK_BITS-1:0]      LOCK_ACTIVE_O,
  output logic                      ANY_LOCKED_O
);

  // lock status of one page under a given lock byte
  function automatic logic page_locked(input logic [PAGE_W-1:0]    pg,
                                       input logic [LOCK_BITS-1:0] lk);
    logic [LOCK_IDX_W-1:0] idx;
    idx = pg[PAGE_W-1 -: LOCK_IDX_W];
    if (pg == LOCK_PAGE)
      return (lk != LOCK_ERASED); // R12
    return ~lk[idx]; // R19
  endfunction

  // access decision; a debug error is demoted to a silent refusal
  function automatic fpg_verdict_t judge(input logic                 src,
                                         input logic [1:0]           op,
                                         input logic [ADDR_W-1:0]    addr,
                                         input logic [PAGE_W-1:0]    xpage,
                                         input logic [LOCK_BITS-1:0] act,
                                         input logic [LOCK_BITS-1:0] sto,
                                         input logic                 mon_ok);
    fpg_verdict_t          v;
    logic [PAGE_W-1:0]     pg;
    logic                  fw;
    logic                  any;
    logic                  from_lk;
    pg      = addr[PAGE_LSB +: PAGE_W];
    fw      = (src == SRC_FW);
    any     = (act != LOCK_ERASED);
    from_lk = page_locked(xpage, act);
    if (op == OP_DEV_ERASE)
      v = fw ? VERDICT_ERR : VERDICT_OK; // R16
    else if (addr >= RESERVED_BASE)
      v = VERDICT_ERR; // R9
    else if (fw && (op != OP_READ) && !mon_ok)
      v = VERDICT_ERR; // R15
    else if ((op == OP_ERASE) && (pg == LOCK_PAGE))
      v = (fw || any) ? VERDICT_ERR : VERDICT_OK; // R5 R6
    else if ((op == OP_WRITE) && (addr == LOCK_ADDR) && (sto != LOCK_ERASED))
      v = VERDICT_ERR; // R7 R8 R13
    else if (page_locked(pg, act))
      v = (fw && from_lk) ? VERDICT_OK : VERDICT_ERR; // R2 R3 R4
    else
      v = VERDICT_OK; // R1
    if (!fw && (v == VERDICT_ERR))
      v = VERDICT_REFUSE; // R11
    return v;
  endfunction

  fpg_state_t               state_q, state_d;
  logic [LOCK_BITS-1:0]     active_q, active_d;
  logic [LOCK_BITS-1:0]     stored_q, stored_d;
  logic                     grant_q, grant_d;
  logic [1:0]               gop_q, gop_d;
  logic [ADDR_W-1:0]        gaddr_q, gaddr_d;
  logic [7:0]               gdata_q, gdata_d;
  logic                     refuse_q, refuse_d;
  logic                     ferr_rst_q, ferr_rst_d;
  logic                     any_q, any_d;
  fpg_verdict_t             verdict;
  logic                     take;
  logic                     mon_ok;
  logic                     smon_en;
  logic                     pf_sel;
  logic                     dev_erase_now;

  // a request is looked at only while running and outside a device reset
  assign take    = REQ_VALID_I && (state_q == ST_RUN) && !DEV_RESET_I;
  assign mon_ok  = smon_en && pf_sel;
  assign verdict = judge(REQ_SRC_I, REQ_OP_I, REQ_ADDR_I, FW_EXEC_PAGE_I,
                         active_q, stored_q, mon_ok);
  assign dev_erase_now = take && (verdict == VERDICT_OK) && (REQ_OP_I == OP_DEV_ERASE);

  // control and lock state next values
  always_comb
  begin
    state_d    = state_q;
    active_d   = active_q;
    stored_d   = stored_q;
    grant_d    = 1'b0;
    gop_d      = gop_q;
    gaddr_d    = gaddr_q;
    gdata_d    = gdata_q;
    refuse_d   = 1'b0;
    ferr_rst_d = 1'b0;
    case (state_q)
      ST_LOAD:
      begin
        // the lock byte is caught after release, never under the async reset
        active_d = LOCK_BYTE_NV_I;
        stored_d = LOCK_BYTE_NV_I;
        state_d  = ST_RUN;
      end
      ST_RUN:
      begin
        if (DEV_RESET_I)
          active_d = stored_q; // R14
        else if (take)
        begin
          case (verdict)
            VERDICT_OK:
            begin
              grant_d = 1'b1;
              gop_d   = REQ_OP_I;
              gaddr_d = REQ_ADDR_I;
              gdata_d = REQ_WDATA_I;
              if (REQ_OP_I == OP_DEV_ERASE)
              begin
                // whole array is blank, so nothing is left to protect
                stored_d = LOCK_ERASED; // R16
                active_d = LOCK_ERASED;
              end
              else if ((REQ_OP_I == OP_ERASE) && (REQ_ADDR_I[PAGE_LSB +: PAGE_W] == LOCK_PAGE))
                stored_d = LOCK_ERASED; // R5
              else if ((REQ_OP_I == OP_WRITE) && (REQ_ADDR_I == LOCK_ADDR))
                stored_d = stored_q & REQ_WDATA_I; // R14
            end
            VERDICT_REFUSE:
              refuse_d = 1'b1; // R11
            VERDICT_ERR:
            begin
              ferr_rst_d = 1'b1; // R2
              state_d    = ST_HALT;
            end
            default:
              refuse_d = 1'b1;
          endcase
        end
      end
      ST_HALT:
      begin
        // device waits for its reset; nothing is granted until that reset is released
        if (DEV_RESET_I)
        begin
          active_d = stored_q; // R14
          state_d  = ST_RUN;
        end
      end
      default:
        state_d = ST_LOAD;
    endcase
    any_d = (active_d != LOCK_ERASED);
  end

  // register the control and lock state
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      state_q    <= ST_LOAD;
      active_q   <= LOCK_ERASED;
      stored_q   <= LOCK_ERASED;
      grant_q    <= 1'b0;
      gop_q      <= OP_READ;
      gaddr_q    <= '0;
      gdata_q    <= 8'h00;
      refuse_q   <= 1'b0;
      ferr_rst_q <= 1'b0;
      any_q      <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      active_q   <= active_d;
      stored_q   <= stored_d;
      grant_q    <= grant_d;
      gop_q      <= gop_d;
      gaddr_q    <= gaddr_d;
      gdata_q    <= gdata_d;
      refuse_q   <= refuse_d;
      ferr_rst_q <= ferr_rst_d;
      any_q      <= any_d;
    end
  end

  // supply monitor and reset-cause record
  fpg_reset_cause u_cause (
    .clk_i                   (CORE_CLK_I),
    .rst_i                   (RESET_I),
    .dev_reset_i             (DEV_RESET_I),
    .err_i                   (ferr_rst_q),
    .smon_en_we_i            (SMON_EN_WE_I),
    .smon_en_i               (SMON_EN_I),
    .pf_sel_we_i             (PF_SEL_WE_I),
    .pf_sel_i                (PF_SEL_I),
    .supply_monitor_enable_o (smon_en),
    .power_fail_reset_flag_o (pf_sel),
    .flash_error_flag_o      (FLASH_ERROR_FLAG_O)
  );

  assign SUPPLY_MONITOR_ENABLE_O = smon_en;
  assign POWER_FAIL_RESET_FLAG_O = pf_sel;
  assign GRANT_O             = grant_q;
  assign GRANT_OP_O          = gop_q;
  assign GRANT_ADDR_O        = gaddr_q;
  assign GRANT_WDATA_O       = gdata_q;
  assign REFUSE_O            = refuse_q;
  assign FLASH_ERROR_RESET_O = ferr_rst_q;
  assign LOCK_ACTIVE_O       = active_q;
  assign ANY_LOCKED_O        = any_q;

  // debug requests never raise a reset
  property p_dbg_no_reset;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REQ_VALID_I && REQ_SRC_I == SRC_DBG) |=> !ferr_rst_q;
  endproperty
  a_dbg_no_reset: assert property (p_dbg_no_reset) else $error("debug request caused reset"); // R11

  property p_reserved_dbg;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_SRC_I == SRC_DBG && REQ_OP_I != OP_DEV_ERASE && REQ_ADDR_I >= RESERVED_BASE)
      |=> refuse_q && !grant_q;
  endproperty
  a_reserved_dbg: assert property (p_reserved_dbg) else $error("reserved debug access not refused"); // R9

  property p_reserved_fw;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_SRC_I == SRC_FW && REQ_ADDR_I >= RESERVED_BASE)
      |=> ferr_rst_q ##1 (state_q == ST_HALT);
  endproperty
  a_reserved_fw: assert property (p_reserved_fw) else $error("reserved firmware access no reset"); // R9

  property p_monitor_gate;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_SRC_I == SRC_FW && REQ_OP_I != OP_READ && !(smon_en && pf_sel))
      |=> ferr_rst_q && !grant_q;
  endproperty
  a_monitor_gate: assert property (p_monitor_gate) else $error("modify without monitor not reset"); // R15

  property p_unlocked_open;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_OP_I == OP_READ && REQ_ADDR_I < RESERVED_BASE
      && REQ_ADDR_I[PAGE_LSB +: PAGE_W] != LOCK_PAGE
      && !page_locked(REQ_ADDR_I[PAGE_LSB +: PAGE_W], active_q))
      |=> grant_q && gaddr_q == $past(REQ_ADDR_I);
  endproperty
  a_unlocked_open: assert property (p_unlocked_open) else $error("unlocked read not granted"); // R1

  property p_lock_deferred;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (state_q == ST_RUN && !DEV_RESET_I && !dev_erase_now) |=> $stable(active_q);
  endproperty
  a_lock_deferred: assert property (p_lock_deferred) else $error("lock changed without reset"); // R14

  property p_flag_after_reset;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (state_q == ST_HALT && DEV_RESET_I) |=> FLASH_ERROR_FLAG_O;
  endproperty
  a_flag_after_reset: assert property (p_flag_after_reset) else $error("error flag not set after reset"); // R10

  property p_lock_page_dbg;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_SRC_I == SRC_DBG && REQ_OP_I != OP_DEV_ERASE && active_q != LOCK_ERASED
      && REQ_ADDR_I < RESERVED_BASE && REQ_ADDR_I[PAGE_LSB +: PAGE_W] == LOCK_PAGE)
      |=> refuse_q;
  endproperty
  a_lock_page_dbg: assert property (p_lock_page_dbg) else $error("lock page open to debug"); // R3

  property p_lock_byte_once;
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && REQ_SRC_I == SRC_FW && REQ_OP_I == OP_WRITE && REQ_ADDR_I == LOCK_ADDR
      && stored_q != LOCK_ERASED) |=> ferr_rst_q && $stable(stored_q);
  endproperty
  a_lock_byte_once: assert property (p_lock_byte_once) else $error("written lock byte modified"); // R13

endmodule // fpg_flash_page_lock_guard
`default_nettype wire

/* File: fpg_pkg.sv */
`default_nettype none
package fpg_pkg;

  // flash geometry: 32 pages of 512 bytes, reserved area above the top page
  localparam int              ADDR_W         = 15;
  localparam int              PAGE_W         = 5;
  localparam int              PAGE_LSB       = 9;
  localparam int              LOCK_BITS      = 8;
  localparam int              LOCK_IDX_W     = 3;
  localparam logic [ADDR_W-1:0] RESERVED_BASE = 15'h4000;
  localparam logic [ADDR_W-1:0] LOCK_ADDR     = 15'h3FFF;
  localparam logic [PAGE_W-1:0] LOCK_PAGE     = 5'h1F;
  localparam logic [LOCK_BITS-1:0] LOCK_ERASED = 8'hFF;

  // requester codes
  localparam logic            SRC_FW         = 1'b0;
  localparam logic            SRC_DBG        = 1'b1;

  // reset values of the supply monitor and reset-cause state
  localparam logic            SMON_EN_POR    = 1'b1;
  localparam logic            PF_SEL_POR     = 1'b1;
  localparam logic            FERR_POR       = 1'b0;

  typedef enum logic [1:0] {
    OP_READ      = 2'h0,
    OP_WRITE     = 2'h1,
    OP_ERASE     = 2'h2,
    OP_DEV_ERASE = 2'h3
  } fpg_op_t;

  typedef enum logic [1:0] {
    VERDICT_OK     = 2'h0,
    VERDICT_REFUSE = 2'h1,
    VERDICT_ERR    = 2'h2
  } fpg_verdict_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_RUN  = 3'h2,
    ST_HALT = 3'h4
  } fpg_state_t;

endpackage
`default_nettype wire

/* File: fpg_reset_cause.sv */
`timescale 1ns/10ps
`default_nettype none
module fpg_reset_cause
  import fpg_pkg::*;
(
  // clock and power-on reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // device reset and error event
  input  wire logic dev_reset_i,
  input  wire logic err_i,
  // firmware writes of the monitor control bits
  input  wire logic smon_en_we_i,
  input  wire logic smon_en_i,
  input  wire logic pf_sel_we_i,
  input  wire logic pf_sel_i,
  // state
  output logic      supply_monitor_enable_o,
  output logic      power_fail_reset_flag_o,
  output logic      flash_error_flag_o
);

  logic smon_en_q, smon_en_d;
  logic pf_sel_q, pf_sel_d;
  logic ferr_q, ferr_d;
  logic pend_q, pend_d;

  // next values; a device reset other than power-on keeps the monitor state
  always_comb
  begin
    smon_en_d = smon_en_q;
    pf_sel_d  = pf_sel_q;
    ferr_d    = ferr_q;
    pend_d    = pend_q | err_i;
    if (dev_reset_i)
    begin
      ferr_d = pend_q | err_i; // R10
      pend_d = 1'b0;
    end
    else
    begin
      if (smon_en_we_i)
        smon_en_d = smon_en_i;
      if (pf_sel_we_i)
        pf_sel_d = pf_sel_i;
    end
  end

  // power-on brings the monitor up enabled and selected
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      smon_en_q <= SMON_EN_POR; // R18
      pf_sel_q  <= PF_SEL_POR;
      ferr_q    <= FERR_POR;
      pend_q    <= 1'b0;
    end
    else
    begin
      smon_en_q <= smon_en_d;
      pf_sel_q  <= pf_sel_d;
      ferr_q    <= ferr_d;
      pend_q    <= pend_d;
    end
  end

  assign supply_monitor_enable_o = smon_en_q;
  assign power_fail_reset_flag_o = pf_sel_q;
  assign flash_error_flag_o      = ferr_q;

endmodule // fpg_reset_cause
`default_nettype wire

/* File: fpg_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: a slow reset controller answering flash error resets, and the
// nonvolatile lock byte cell that granted writes and erases update
module fpg_far_side
  import fpg_pkg::*;
(
  // clock and power-on reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // answers from the guard
  input  wire logic              err_rst_i,
  input  wire logic              grant_i,
  input  wire logic [1:0]        grant_op_i,
  input  wire logic [ADDR_W-1:0] grant_addr_i,
  input  wire logic [7:0]        grant_wdata_i,
  // extra device reset asked for by the bench
  input  wire logic              kick_i,
  // device reset and stored lock byte
  output logic                   dev_reset_o,
  output logic [LOCK_BITS-1:0]   lock_nv_o
);
  logic [2:0] err_sh_q;

  // reset comes four cycles late so the guard must hold its halt meanwhile
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_sh_q    <= 3'h0;
      dev_reset_o <= 1'b0;
    end
    else
    begin
      err_sh_q    <= {err_sh_q[1:0], err_rst_i};
      dev_reset_o <= err_sh_q[2] | kick_i;
    end
  end

  // nonvolatile cell: power-on reset leaves it alone
  initial lock_nv_o = LOCK_ERASED;
  always @(posedge clk_i)
  begin
    if (grant_i && (grant_op_i == OP_DEV_ERASE))
      lock_nv_o <= LOCK_ERASED;
    else if (grant_i && (grant_op_i == OP_ERASE) && (grant_addr_i[13:9] == LOCK_PAGE))
      lock_nv_o <= LOCK_ERASED;
    else if (grant_i && (grant_op_i == OP_WRITE) && (grant_addr_i == LOCK_ADDR))
      lock_nv_o <= lock_nv_o & grant_wdata_i;
  end
endmodule // fpg_far_side
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fpg_pkg::*;
  localparam logic [2:0] G = 3'h4, R = 3'h2, E = 3'h1;
  logic clk, rst, dev, valid, src, smon_we, smon, pf_we, pf, kick;
  logic [1:0] op, g_op;
  logic [14:0] addr, g_addr;
  logic [7:0] wd, g_wd, nv, act;
  logic [4:0] xp;
  logic grant, refuse, err, flag, smon_o, pf_o, anyl;
  int err_total = 0;
  int checked = 0;

  fpg_flash_page_lock_guard uut (.CORE_CLK_I(clk), .RESET_I(rst), .DEV_RESET_I(dev), .LOCK_BYTE_NV_I(nv),
    .REQ_VALID_I(valid), .REQ_SRC_I(src), .REQ_OP_I(op), .REQ_ADDR_I(addr), .REQ_WDATA_I(wd),
    .FW_EXEC_PAGE_I(xp), .SMON_EN_WE_I(smon_we), .SMON_EN_I(smon), .PF_SEL_WE_I(pf_we), .PF_SEL_I(pf),
    .GRANT_O(grant), .GRANT_OP_O(g_op), .GRANT_ADDR_O(g_addr), .GRANT_WDATA_O(g_wd), .REFUSE_O(refuse),
    .FLASH_ERROR_RESET_O(err), .FLASH_ERROR_FLAG_O(flag), .SUPPLY_MONITOR_ENABLE_O(smon_o),
    .POWER_FAIL_RESET_FLAG_O(pf_o), .LOCK_ACTIVE_O(act), .ANY_LOCKED_O(anyl));
  fpg_far_side far (.clk_i(clk), .rst_i(rst), .err_rst_i(err), .grant_i(grant), .grant_op_i(g_op),
    .grant_addr_i(g_addr), .grant_wdata_i(g_wd), .kick_i(kick), .dev_reset_o(dev), .lock_nv_o(nv));

  // 20 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // power-on reset held two cycles; first request one cycle after release
  task automatic por();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask

  // extra device reset without any error pending
  task automatic dev_rst();
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // one request; an error answer waits for the reset controller and its flag
  task automatic ck(input logic s, input logic [1:0] o, input logic [14:0] a, input logic [7:0] d,
                    input logic [4:0] x, input logic [2:0] exp);
    int n;
    src = s; op = o; addr = a; wd = d; xp = x;
    valid = 1'b1;
    @(negedge clk);
    if (exp != E)
      valid = 1'b0;
    chk({grant, refuse, err}, exp, "answer");
    if (exp == G)
    begin
      chk(g_addr, a, "grant_addr");
      chk(g_op, o, "grant_op");
      chk(g_wd, d, "grant_wdata");
    end
    if (exp == E)
    begin
      @(negedge clk);
      valid = 1'b0;
      chk({grant, refuse, err}, 3'h0, "halted");
      for (n = 0; n < 20 && dev !== 1'b1; n++)
        @(negedge clk);
      if (n == 20)
      begin
        chk(1'b0, 1'b1, "dev_reset_wait");
        finish_test();
      end
      else
      begin
        @(negedge clk);
        chk(flag, 1'b1, "error_flag");
        @(negedge clk);
      end
    end
    else
      @(negedge clk);
  endtask

  // monitor control write; value seen one edge later
  task automatic mon(input logic sel, input logic v);
    if (sel)
    begin
      pf_we = 1'b1;
      pf = v;
    end
    else
    begin
      smon_we = 1'b1;
      smon = v;
    end
    @(negedge clk);
    smon_we = 1'b0;
    pf_we = 1'b0;
  endtask

  task automatic t_open();
    chk({act, anyl, smon_o, pf_o, flag}, {8'hFF, 4'h6}, "reset_state");
    ck(SRC_FW, OP_READ, 15'h0010, 8'h00, 5'h05, G);
    ck(SRC_FW, OP_WRITE, 15'h0010, 8'h5A, 5'h05, G);
    ck(SRC_DBG, OP_ERASE, 15'h0400, 8'h00, 5'h00, G);
    ck(SRC_DBG, OP_WRITE, 15'h3E00, 8'hA5, 5'h00, G);
    ck(SRC_DBG, OP_READ, LOCK_ADDR, 8'h00, 5'h00, G);
    ck(SRC_FW, OP_READ, LOCK_ADDR, 8'h00, 5'h05, G);
    $display("open pages done");
  endtask

  task automatic t_reserved();
    ck(SRC_DBG, OP_READ, RESERVED_BASE, 8'h00, 5'h00, R);
    ck(SRC_DBG, OP_ERASE, 15'h7FFF, 8'h00, 5'h00, R);
    ck(SRC_FW, OP_WRITE, 15'h7FFF, 8'h11, 5'h05, E);
    dev_rst();
    chk(flag, 1'b0, "flag_cleared");
    $display("reserved area done");
  endtask

  task automatic t_monitor();
    mon(1'b0, 1'b0);
    chk(smon_o, 1'b0, "monitor_off");
    ck(SRC_FW, OP_WRITE, 15'h0010, 8'h22, 5'h05, E);
    chk(smon_o, 1'b0, "monitor_kept");
    ck(SRC_FW, OP_READ, 15'h0010, 8'h00, 5'h05, G);
    mon(1'b0, 1'b1);
    mon(1'b1, 1'b0);
    chk(pf_o, 1'b0, "select_off");
    ck(SRC_FW, OP_ERASE, 15'h0400, 8'h00, 5'h05, E);
    mon(1'b0, 1'b0);
    por();
    chk({smon_o, pf_o}, 2'h3, "monitor_por");
    ck(SRC_FW, OP_WRITE, 15'h0010, 8'h33, 5'h05, G);
    $display("supply monitor done");
  endtask

  task automatic t_lock();
    ck(SRC_FW, OP_ERASE, 15'h3E00, 8'h00, 5'h05, E);
    ck(SRC_DBG, OP_ERASE, 15'h3E00, 8'h00, 5'h00, G);
    ck(SRC_FW, OP_WRITE, LOCK_ADDR, 8'hFE, 5'h05, G);
    chk(act, 8'hFF, "lock_deferred");
    ck(SRC_FW, OP_WRITE, LOCK_ADDR, 8'hFC, 5'h05, E);
    chk({act, anyl}, 9'h1FD, "lock_applied");
    ck(SRC_DBG, OP_READ, 15'h0600, 8'h00, 5'h00, R);
    ck(SRC_DBG, OP_READ, 15'h0800, 8'h00, 5'h00, G);
    ck(SRC_FW, OP_READ, 15'h0010, 8'h00, 5'h0A, E);
    ck(SRC_FW, OP_READ, 15'h0010, 8'h00, 5'h01, G);
    ck(SRC_FW, OP_READ, LOCK_ADDR, 8'h00, 5'h01, G);
    ck(SRC_DBG, OP_READ, LOCK_ADDR, 8'h00, 5'h00, R);
    ck(SRC_FW, OP_WRITE, 15'h3E00, 8'h00, 5'h0A, E);
    ck(SRC_DBG, OP_WRITE, LOCK_ADDR, 8'hFF, 5'h00, R);
    ck(SRC_FW, OP_WRITE, LOCK_ADDR, 8'hFF, 5'h01, E);
    ck(SRC_DBG, OP_ERASE, 15'h3E00, 8'h00, 5'h00, R);
    ck(SRC_FW, OP_ERASE, 15'h3E00, 8'h00, 5'h01, E);
    ck(SRC_FW, OP_DEV_ERASE, 15'h0000, 8'h00, 5'h01, E);
    ck(SRC_DBG, OP_DEV_ERASE, 15'h0000, 8'h00, 5'h00, G);
    chk({act, anyl}, 9'h1FE, "unlocked");
    ck(SRC_DBG, OP_READ, 15'h0010, 8'h00, 5'h00, G);
    $display("page locking done");
  endtask

  // stimulus changes only at falling edges
  initial
  begin
    {valid, src, smon_we, smon, pf_we, pf, kick, op, addr, wd, xp} = '0;
    rst = 1'b1;
    @(negedge clk);
    por();
    t_open();
    t_reserved();
    t_monitor();
    t_lock();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
